// ### hdl/mmx_params.svh
// Constants for the move and multiply instruction executor
`ifndef MMX_PARAMS_SVH
`define MMX_PARAMS_SVH

// ---------------------------------------------
// Opcode fields of the upper instruction byte
// ---------------------------------------------
`define MMX_OP_LDL_HI 8'h0e
`define MMX_OP_MLL_HI 8'h0d
`define MMX_OP_STF_HI 7'h37
`define MMX_OP_MLF_HI 7'h01
`define MMX_ACC_BIT 8

// ---------------------------------------------
// Data space layout
// ---------------------------------------------
`define MMX_INDEX_LIMIT 8'h5f
`define MMX_ACCESS_SPLIT 8'h60
`define MMX_ACCESS_LO_BANK 4'h0
`define MMX_ACCESS_HI_BANK 4'hf

// ---------------------------------------------
// Reset values and timing
// ---------------------------------------------
`define MMX_ACC_RST 8'h00
`define MMX_PROD_RST 8'h00
`define MMX_CLK_PER_INSTR 4

`endif

// ### hdl/mmx_pkg.sv
// Types shared by the move and multiply instruction executor
package mmx_pkg;

   // ---------------------------------------------
   // Quarter phases of one instruction cycle
   // ---------------------------------------------
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000, // No instruction in flight
      PH_Q1 = 3'b001, // Decode
      PH_Q2 = 3'b010, // Read operand
      PH_Q3 = 3'b011, // Process data
      PH_Q4 = 3'b100 // Write destination
   } mmx_phase_type;

   // ---------------------------------------------
   // Decoded operations
   // ---------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE = 3'b000, // Not handled here
      OP_LDL = 3'b001, // load_literal_to_acc
      OP_STF = 3'b010, // store_acc_to_file
      OP_MLL = 3'b011, // multiply_acc_by_literal
      OP_MLF = 3'b100 // multiply_acc_by_file
   } mmx_op_type;

endpackage : mmx_pkg

// ### hdl/mmx_addr_gen.sv
// File register address generator for byte-oriented instructions
`include "mmx_params.svh"

module mmx_addr_gen (
   input wire logic [7:0] file_field, // File address field of the word
   input wire logic access_bit, // Bank access bit
   input wire logic [3:0] bank_sel, // Bank select register value
   input wire logic ext_en, // Extended instruction set on
   input wire logic [11:0] index_base, // Pointer for indexed offset mode
   output logic [11:0] file_addr, // Full data space address
   output logic indexed // Indexed offset mode in use
);

   // ---------------------------------------------
   // Bank resolution
   // ---------------------------------------------
   // Field spans all 256 bytes of one bank
   always_comb begin
      indexed = 1'b0;
      if (access_bit) begin
         // Banked access from the select register
         file_addr = {bank_sel, file_field};
      end else if (ext_en && (file_field <= `MMX_INDEX_LIMIT)) begin
         // Offset from the index pointer; wraps in the 4K space
         indexed = 1'b1;
         file_addr = index_base + {4'h0, file_field};
      end else if (file_field < `MMX_ACCESS_SPLIT) begin
         // Access bank below 0x60 is RAM of bank 0
         file_addr = {`MMX_ACCESS_LO_BANK, file_field};
      end else begin
         // Access bank from 0x60 upward maps the top bank
         file_addr = {`MMX_ACCESS_HI_BANK, file_field};
      end
   end

endmodule : mmx_addr_gen

// ### hdl/mmx_mul8.sv
// Unsigned 8 by 8 shift-and-add multiplier
module mmx_mul8 (
   input wire logic [7:0] mul_a, // Multiplicand
   input wire logic [7:0] mul_b, // Multiplier
   output logic [15:0] product // Unsigned product
);

   // ---------------------------------------------
   // Partial products and running sum
   // ---------------------------------------------
   logic [15:0] part [8]; // One shifted copy per multiplier bit
   logic [15:0] sum [9]; // Running sums

   assign sum[0] = 16'h0000;

   // Plain adder chain: fits in one clock at this rate, no pipeline
   for (genvar i = 0; i < 8; i++) begin : g_row
      assign part[i] = mul_b[i] ? ({8'h00, mul_a} << i) : 16'h0000;
      assign sum[i + 1] = sum[i] + part[i];
   end

   // No carry out: 8x8 never exceeds 16 bits
   assign product = sum[8];

endmodule : mmx_mul8

// ### hdl/mmx_instr_exec.sv
// Executor for literal load, store and the two unsigned multiplies
//
// How it works
// - Literal load puts immediate into accumulator
// - Literal load changes no status flag
// - Literal load finishes in one instruction cycle
// - Store copies accumulator into addressed file register
// - File field reaches all 256 bank bytes
// - Access bit picks access bank or selected bank
// - Extended set: low fields with access bit clear use indexed offset
// - Literal multiply, accumulator kept unchanged
// - Product high and low bytes stored
// - Multiplies touch no status flag
// - File multiply uses accumulator and file register
// - File multiply decode; operands left unchanged
`include "mmx_params.svh"

module mmx_instr_exec (
   input wire logic clk_sys, // Core clock, 250 MHz
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic [15:0] instr_word, // Fetched instruction word
   input wire logic instr_valid, // Instruction word offered
   output logic instr_ready, // Executor takes a word this cycle
   input wire logic ext_instr_en, // Extended instruction set on
   input wire logic [3:0] bank_select_reg, // Bank number for banked access
   input wire logic [11:0] index_base, // Pointer for indexed offset mode
   output logic file_rd_en, // File register read strobe
   output logic [11:0] file_rd_addr, // File register read address
   input wire logic [7:0] file_rd_data, // Read data, cycle after strobe
   output logic file_wr_en, // File register write strobe
   output logic [11:0] file_wr_addr, // File register write address
   output logic [7:0] file_wr_data, // File register write data
   output logic [7:0] acc_value, // Working accumulator
   output logic [7:0] product_high, // Upper product byte
   output logic [7:0] product_low, // Lower product byte
   output logic instr_done, // Pulse in the write quarter
   output logic instr_unknown // Pulse: word not handled here
);

   // ---------------------------------------------
   // Opcode decode
   // ---------------------------------------------
   // Used by the decode register and by the checks below
   function automatic mmx_pkg::mmx_op_type op_of(input logic [15:0] word);
      if (word[15:8] == `MMX_OP_LDL_HI) begin
         op_of = mmx_pkg::OP_LDL;
      end else if (word[15:8] == `MMX_OP_MLL_HI) begin
         op_of = mmx_pkg::OP_MLL;
      end else if (word[15:9] == `MMX_OP_STF_HI) begin
         op_of = mmx_pkg::OP_STF;
      end else if (word[15:9] == `MMX_OP_MLF_HI) begin
         op_of = mmx_pkg::OP_MLF;
      end else begin
         op_of = mmx_pkg::OP_NONE;
      end
   endfunction : op_of

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   mmx_pkg::mmx_phase_type phase_r; // Current quarter
   mmx_pkg::mmx_phase_type phase_nxt; // Next quarter
   mmx_pkg::mmx_op_type op_r; // Operation in flight
   logic [15:0] instr_r; // Captured word
   logic [11:0] addr_r; // Resolved file address
   logic [11:0] addr_nxt; // From the address generator
   logic [7:0] acc_r; // Accumulator
   logic [15:0] calc_r; // Product from the process quarter
   logic [7:0] prod_hi_r; // Product high byte
   logic [7:0] prod_lo_r; // Product low byte
   logic [7:0] mul_b; // Second multiplier operand
   logic [15:0] mul_out; // Multiplier result
   logic take; // Word taken this cycle
   logic is_mul; // Operation is a multiply

   // ---------------------------------------------
   // Sub blocks
   // ---------------------------------------------
   mmx_addr_gen u_addr (
      .file_field(instr_r[7:0]),
      .access_bit(instr_r[`MMX_ACC_BIT]),
      .bank_sel(bank_select_reg),
      .ext_en(ext_instr_en),
      .index_base(index_base),
      .file_addr(addr_nxt),
      .indexed()
   );

   mmx_mul8 u_mul (
      .mul_a(acc_r),
      .mul_b(mul_b),
      .product(mul_out)
   );

   // ---------------------------------------------
   // Handshake and operand select
   // ---------------------------------------------
   // A new word may enter in the write quarter, so instructions
   // run back to back at one per four clocks
   assign instr_ready = (phase_r == mmx_pkg::PH_IDLE) || (phase_r == mmx_pkg::PH_Q4);
   assign take = instr_valid && instr_ready;
   assign is_mul = (op_r == mmx_pkg::OP_MLL) || (op_r == mmx_pkg::OP_MLF);

   // Literal operand or file data; file data is valid in the third quarter
   assign mul_b = (op_r == mmx_pkg::OP_MLF) ? file_rd_data : instr_r[7:0];

   // ---------------------------------------------
   // Quarter sequencer
   // ---------------------------------------------
   always_comb begin
      phase_nxt = phase_r;
      unique case (phase_r)
         mmx_pkg::PH_IDLE: begin
            if (take) begin
               phase_nxt = mmx_pkg::PH_Q1;
            end
         end
         mmx_pkg::PH_Q1: begin
            phase_nxt = mmx_pkg::PH_Q2;
         end
         mmx_pkg::PH_Q2: begin
            phase_nxt = mmx_pkg::PH_Q3;
         end
         mmx_pkg::PH_Q3: begin
            phase_nxt = mmx_pkg::PH_Q4;
         end
         mmx_pkg::PH_Q4: begin
            // One instruction cycle ends here
            phase_nxt = take ? mmx_pkg::PH_Q1 : mmx_pkg::PH_IDLE;
         end
         default: begin
            // Unused codes fall back to idle
            phase_nxt = mmx_pkg::PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= mmx_pkg::PH_IDLE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // ---------------------------------------------
   // Word capture and decode
   // ---------------------------------------------
   // Word held for the whole cycle so a changing fetch bus is harmless
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         instr_r <= 16'h0000;
      end else if (take) begin
         instr_r <= instr_word;
      end
   end

   // Decode in the first quarter
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         op_r <= mmx_pkg::OP_NONE;
      end else if (take) begin
         op_r <= op_of(instr_word);
      end
   end

   // Address resolved at the end of decode, so bank changes later
   // in the cycle do not move the access
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= 12'h000;
      end else if (phase_r == mmx_pkg::PH_Q1) begin
         addr_r <= addr_nxt;
      end
   end

   // ---------------------------------------------
   // File register port
   // ---------------------------------------------
   // Read quarter: store also reads, matching the core's dummy read
   assign file_rd_en = (phase_r == mmx_pkg::PH_Q2)
      && ((op_r == mmx_pkg::OP_MLF) || (op_r == mmx_pkg::OP_STF));
   assign file_rd_addr = addr_r;

   // Write quarter only; the multiply never writes its file operand
   assign file_wr_en = (phase_r == mmx_pkg::PH_Q4) && (op_r == mmx_pkg::OP_STF);
   assign file_wr_addr = addr_r;
   assign file_wr_data = acc_r;

   // ---------------------------------------------
   // Process quarter: product capture
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         calc_r <= 16'h0000;
      end else if ((phase_r == mmx_pkg::PH_Q3) && is_mul) begin
         calc_r <= mul_out;
      end
   end

   // ---------------------------------------------
   // Write quarter: destinations
   // ---------------------------------------------
   // Only the literal load writes the accumulator; multiplies keep it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= `MMX_ACC_RST;
      end else if ((phase_r == mmx_pkg::PH_Q4) && (op_r == mmx_pkg::OP_LDL)) begin
         acc_r <= instr_r[7:0];
      end
   end

   // Product pair; a zero result raises nothing since no flag path exists
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prod_hi_r <= `MMX_PROD_RST;
         prod_lo_r <= `MMX_PROD_RST;
      end else if ((phase_r == mmx_pkg::PH_Q4) && is_mul) begin
         prod_hi_r <= calc_r[15:8];
         prod_lo_r <= calc_r[7:0];
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   // No status flag output exists: none of these four alter flags
   assign acc_value = acc_r;
   assign product_high = prod_hi_r;
   assign product_low = prod_lo_r;
   assign instr_done = (phase_r == mmx_pkg::PH_Q4);
   assign instr_unknown = (phase_r == mmx_pkg::PH_Q4) && (op_r == mmx_pkg::OP_NONE);

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   sequence s_take_ldl;
      take && (op_of(instr_word) == mmx_pkg::OP_LDL);
   endsequence

   sequence s_take_mll;
      take && (op_of(instr_word) == mmx_pkg::OP_MLL);
   endsequence

   sequence s_take_stf;
      take && (op_of(instr_word) == mmx_pkg::OP_STF);
   endsequence

   sequence s_quarters;
      (phase_r == mmx_pkg::PH_Q1) ##1 (phase_r == mmx_pkg::PH_Q2)
      ##1 (phase_r == mmx_pkg::PH_Q3) ##1 (phase_r == mmx_pkg::PH_Q4);
   endsequence

   a_ldl_loads_acc: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      s_take_ldl |-> ##5 (acc_r == $past(instr_word[7:0], 5)))
      else $error("literal load did not reach the accumulator");

   a_ldl_one_cycle: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      s_take_ldl |-> ##1 s_quarters)
      else $error("literal load did not finish in four quarters");

   a_quarter_order: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      take |-> ##1 s_quarters)
      else $error("quarter sequence broken");

   // Banked stores must land at the bank seen at the end of decode
   a_stf_writes_file: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      s_take_stf |-> ##4 (file_wr_en && (file_wr_data == acc_r)
         && (!$past(instr_word[`MMX_ACC_BIT], 4)
         || (file_wr_addr == {$past(bank_select_reg, 3), $past(instr_word[7:0], 4)}))))
      else $error("store did not write the accumulator");

   // Judged from the word taken four clocks earlier, not from op_r
   a_wr_only_store: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      file_wr_en |-> ($past(take, 4)
         && ($past(op_of(instr_word), 4) == mmx_pkg::OP_STF)))
      else $error("file write outside a store");

   a_bank_from_select: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ((phase_r == mmx_pkg::PH_Q2) && instr_r[`MMX_ACC_BIT])
      |-> (file_rd_addr == {$past(bank_select_reg), instr_r[7:0]}))
      else $error("banked address wrong");

   a_indexed_addr: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ((phase_r == mmx_pkg::PH_Q2) && !instr_r[`MMX_ACC_BIT] && $past(ext_instr_en)
         && (instr_r[7:0] <= `MMX_INDEX_LIMIT))
      |-> (file_rd_addr == ($past(index_base) + {4'h0, instr_r[7:0]})))
      else $error("indexed offset address wrong");

   a_mul_keeps_acc: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ((phase_r == mmx_pkg::PH_Q4) && is_mul) |=> (acc_r == $past(acc_r)))
      else $error("multiply changed the accumulator");

   a_mll_product: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      s_take_mll |-> ##5 ({prod_hi_r, prod_lo_r}
         == (16'($past(acc_r, 1)) * 16'($past(instr_word[7:0], 5)))))
      else $error("literal product wrong");

   a_mlf_product: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ((phase_r == mmx_pkg::PH_Q3) && (op_r == mmx_pkg::OP_MLF))
      |-> ##2 ({prod_hi_r, prod_lo_r}
         == (16'($past(acc_r, 2)) * 16'($past(file_rd_data, 2)))))
      else $error("file product wrong");

endmodule : mmx_instr_exec

// ### sim/mmx_instr_exec_test.sv
// Self-checking bench for the move and multiply instruction executor
`define MMX_CHECK(got, exp) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
   end \
end

module mmx_instr_exec_test;
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------
   // One row: inputs beside the outputs they give
   // ---------------------------------------------
   typedef struct packed {
      logic [15:0] word; // Instruction word
      logic [3:0] bank; // Bank select value
      logic ext; // Extended set on
      logic [11:0] ibase; // Indexed pointer
      logic [7:0] rd_data; // File data returned in Q3
      logic rd; // Read strobe expected in Q2
      logic [11:0] addr; // Expected file address
      logic wr; // Write strobe expected in Q4
      logic unk; // Unknown pulse expected
      logic [7:0] acc; // Accumulator afterwards
      logic [15:0] prod; // Product pair afterwards
   } mmx_row_type;

   logic clk_sys; // Core clock
   logic rst_n; // Reset, active low
   logic [15:0] instr_word; // Word offered
   logic instr_valid; // Offer strobe
   logic instr_ready; // Executor takes word
   logic ext_instr_en; // Extended set enable
   logic [3:0] bank_select_reg; // Bank number
   logic [11:0] index_base; // Indexed pointer
   logic file_rd_en; // Read strobe
   logic [11:0] file_rd_addr; // Read address
   logic [7:0] file_rd_data; // Read data
   logic file_wr_en; // Write strobe
   logic [11:0] file_wr_addr; // Write address
   logic [7:0] file_wr_data; // Write data
   logic [7:0] acc_value; // Accumulator
   logic [7:0] product_high; // Product upper byte
   logic [7:0] product_low; // Product lower byte
   logic instr_done; // Write quarter pulse
   logic instr_unknown; // Unhandled word pulse
   int miscompares; // Mismatch count
   int checks_done; // Comparison count
   mmx_row_type rows [15]; // Ordinary cases, run in order

   mmx_instr_exec dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .instr_word(instr_word),
      .instr_valid(instr_valid), .instr_ready(instr_ready),
      .ext_instr_en(ext_instr_en), .bank_select_reg(bank_select_reg),
      .index_base(index_base), .file_rd_en(file_rd_en), .file_rd_addr(file_rd_addr),
      .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
      .file_wr_data(file_wr_data), .acc_value(acc_value), .product_high(product_high),
      .product_low(product_low), .instr_done(instr_done), .instr_unknown(instr_unknown)
   );

   // Free-running 250 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   // Counts, verdict and end of run
   task print_verdict;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   // Bounded wait for instr_ready, seen mid-cycle to avoid edge races
   task wait_ready;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_sys);
         if (instr_ready === 1'b1) return;
      end
      miscompares++;
      print_verdict();
   endtask : wait_ready

   // Offer one word, return file data only in Q3, check every quarter
   task run_row(input mmx_row_type r);
      @(posedge clk_sys);
      instr_word <= r.word;
      instr_valid <= 1'b1;
      bank_select_reg <= r.bank;
      ext_instr_en <= r.ext;
      index_base <= r.ibase;
      wait_ready();
      for (int n = 1; n <= 5; n++) begin
         @(posedge clk_sys);
         instr_valid <= 1'b0;
         instr_word <= ~r.word;
         // Data line shows junk outside its one valid cycle
         file_rd_data <= (n == 3) ? r.rd_data : ~r.rd_data;
         @(negedge clk_sys);
         if (n < 4) begin
            `MMX_CHECK(instr_ready, 1'b0)
            `MMX_CHECK(instr_done, 1'b0)
            `MMX_CHECK(file_wr_en, 1'b0)
         end
         if (n == 2) begin
            `MMX_CHECK(file_rd_en, r.rd)
            if (r.rd) `MMX_CHECK(file_rd_addr, r.addr)
         end
         if (n == 4) begin
            `MMX_CHECK(instr_done, 1'b1)
            `MMX_CHECK(instr_ready, 1'b1)
            `MMX_CHECK(file_wr_en, r.wr)
            `MMX_CHECK(instr_unknown, r.unk)
            if (r.wr) `MMX_CHECK({file_wr_addr, file_wr_data}, {r.addr, r.acc})
         end
         if (n == 5) begin
            `MMX_CHECK(acc_value, r.acc)
            `MMX_CHECK({product_high, product_low}, r.prod)
         end
      end
   endtask : run_row

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      rst_n = 1'b0;
      instr_word = 16'h0000;
      instr_valid = 1'b0;
      ext_instr_en = 1'b0;
      bank_select_reg = 4'h0;
      index_base = 12'h000;
      file_rd_data = 8'h00;
      miscompares = 0;
      checks_done = 0;
      // word, bank, ext, ibase, rd_data, rd, addr, wr, unk, acc, prod
      rows[0] = '{16'h0e5a, 4'h7, 1'b1, 12'h123, 8'h11, 1'b0, 12'h000,
         1'b0, 1'b0, 8'h5a, 16'h0000};
      rows[1] = '{16'h0ee2, 4'h7, 1'b0, 12'h123, 8'h11, 1'b0, 12'h000,
         1'b0, 1'b0, 8'he2, 16'h0000};
      rows[2] = '{16'h0dc4, 4'h7, 1'b0, 12'h123, 8'h11, 1'b0, 12'h000,
         1'b0, 1'b0, 8'he2, 16'had08};
      rows[3] = '{16'h0ec4, 4'h7, 1'b0, 12'h123, 8'h11, 1'b0, 12'h000,
         1'b0, 1'b0, 8'hc4, 16'had08};
      rows[4] = '{16'h0310, 4'h5, 1'b1, 12'h200, 8'hb5, 1'b1, 12'h510,
         1'b0, 1'b0, 8'hc4, 16'h8a94};
      rows[5] = '{16'h0210, 4'h5, 1'b0, 12'h200, 8'h01, 1'b1, 12'h010,
         1'b0, 1'b0, 8'hc4, 16'h00c4};
      rows[6] = '{16'h6f10, 4'h3, 1'b0, 12'h200, 8'h99, 1'b1, 12'h310,
         1'b1, 1'b0, 8'hc4, 16'h00c4};
      rows[7] = '{16'h6e80, 4'h3, 1'b0, 12'h200, 8'h99, 1'b1, 12'hf80,
         1'b1, 1'b0, 8'hc4, 16'h00c4};
      rows[8] = '{16'h6e5f, 4'h3, 1'b1, 12'h0a0, 8'h99, 1'b1, 12'h0ff,
         1'b1, 1'b0, 8'hc4, 16'h00c4};
      rows[9] = '{16'h6e60, 4'h3, 1'b1, 12'h0a0, 8'h99, 1'b1, 12'hf60,
         1'b1, 1'b0, 8'hc4, 16'h00c4};
      rows[10] = '{16'h6fff, 4'hf, 1'b1, 12'h0a0, 8'h99, 1'b1, 12'hfff,
         1'b1, 1'b0, 8'hc4, 16'h00c4};
      rows[11] = '{16'h025f, 4'h3, 1'b1, 12'hff8, 8'hff, 1'b1, 12'h057,
         1'b0, 1'b0, 8'hc4, 16'hc33c};
      rows[12] = '{16'h0000, 4'h3, 1'b0, 12'h000, 8'h99, 1'b0, 12'h000,
         1'b0, 1'b1, 8'hc4, 16'hc33c};
      rows[13] = '{16'h0e00, 4'h3, 1'b0, 12'h000, 8'h99, 1'b0, 12'h000,
         1'b0, 1'b0, 8'h00, 16'hc33c};
      rows[14] = '{16'h0dff, 4'h3, 1'b0, 12'h000, 8'h99, 1'b0, 12'h000,
         1'b0, 1'b0, 8'h00, 16'h0000};
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (rows[i]) run_row(rows[i]);

      // Back to back: second word held through Q1..Q3, taken in Q4
      @(posedge clk_sys);
      instr_word <= 16'h0e03;
      instr_valid <= 1'b1;
      wait_ready();
      for (int n = 1; n <= 9; n++) begin
         @(posedge clk_sys);
         if (n == 1) instr_word <= 16'h0d07;
         if (n == 5) instr_valid <= 1'b0;
         @(negedge clk_sys);
         `MMX_CHECK(instr_done, 1'((n == 4) || (n == 8)))
         if (n < 4) `MMX_CHECK(instr_ready, 1'b0)
         if (n == 5) `MMX_CHECK(acc_value, 8'h03)
         if (n == 9) `MMX_CHECK({acc_value, product_high, product_low}, 24'h030015)
      end

      // Reset in mid-store: nothing of it may complete
      @(posedge clk_sys);
      instr_word <= 16'h6f10;
      instr_valid <= 1'b1;
      wait_ready();
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(negedge clk_sys);
      `MMX_CHECK({file_rd_en, file_wr_en, instr_done, instr_ready}, 4'h1)
      `MMX_CHECK({acc_value, product_high, product_low}, 24'h000000)
      @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int n = 0; n < 6; n++) begin
         @(negedge clk_sys);
         `MMX_CHECK({file_wr_en, instr_done}, 2'h0)
      end
      run_row('{16'h0e33, 4'h0, 1'b0, 12'h000, 8'h00, 1'b0, 12'h000, 1'b0, 1'b0, 8'h33, 16'h0000});
      print_verdict();
   end
endmodule : mmx_instr_exec_test
